// [core/tmf_pkg.sv]
// constants shared by the interval timer: register indices, field positions, codes
// assumes a 32-bit AXI4-Lite bus; register byte address is four times the index
package tmf_pkg;

	// ==========================================
	// bus geometry
	localparam int ADDR_W = 18;
	localparam int IDX_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// register indices (byte address = index * 4)
	localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL = 16'hFFB6;
	localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL_STATUS = 16'hFFB7;
	localparam logic [IDX_W-1:0] IDX_TIMER_COUNT_VALUE = 16'hFFB8;
	localparam logic [IDX_W-1:0] IDX_COMPARE_VALUE = 16'hFFBA;
	localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 16'hFFBC;
	localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 16'hFFBD;
	localparam logic [IDX_W-1:0] IDX_INTERRUPT_ENABLE_TWO = 16'hFFF4;
	localparam logic [IDX_W-1:0] IDX_INTERRUPT_REQUEST_TWO = 16'hFFF7;

	// ==========================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] RST_COMPARE = 16'hFFFF;

	// ==========================================
	// timer_control fields
	localparam int CTL_UPPER_LEVEL = 7;
	localparam int CTL_UPPER_SEL_HI = 6;
	localparam int CTL_UPPER_SEL_LO = 4;
	localparam int CTL_LOWER_LEVEL = 3;
	localparam int CTL_LOWER_SEL_HI = 2;
	localparam int CTL_LOWER_SEL_LO = 0;

	// timer_control_status fields
	localparam int CS_OVF_H = 7;
	localparam int CS_CMP_H = 6;
	localparam int CS_OVIE_H = 5;
	localparam int CS_CCLR_H = 4;
	localparam int CS_OVF_L = 3;
	localparam int CS_CMP_L = 2;
	localparam int CS_OVIE_L = 1;
	localparam int CS_CCLR_L = 0;
	localparam logic [7:0] CS_FLAG_MASK = 8'hCC;

	// interrupt enable / request bit of the upper timer
	localparam int IRQ_UPPER_BIT = 3;

	// own event status / mask bits
	localparam int EV_OVF_H = 3;
	localparam int EV_CMP_H = 2;
	localparam int EV_OVF_L = 1;
	localparam int EV_CMP_L = 0;
	localparam int EV_W = 4;

	// ==========================================
	// clock select codes (3-bit field)
	localparam logic [2:0] SEL_DIV32 = 3'h4;
	localparam logic [2:0] SEL_DIV16 = 3'h5;
	localparam logic [2:0] SEL_DIV4 = 3'h6;
	localparam int SEL_INTERNAL_BIT = 2;

	// prescaler divisors and counter geometry
	localparam int PRESCALE_W = 13;
	localparam int DIV4 = 4;
	localparam int DIV16 = 16;
	localparam int DIV32 = 32;
	localparam int COUNT_W = 16;
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam logic [7:0] BYTE_ONE = 8'h01;

endpackage

// [core/tmf_timer.sv]
// sixteen-bit interval timer with 13-bit prescaler, AXI4-Lite register slave
// assumes one clock aclk, synchronous inputs, ce freezing all state when low
//
// Summary of operation
// R1: 13-bit prescaler counts every clock cycle
// R2: 16-bit readable writable up-counter advances per tick
// R3: input is clock/4, /16, /32 or external
// R4: control register selects 16-bit or two 8-bit
// R5: control register sets both toggle output levels
// R6: upper select 000/001/010 means 16-bit counting
// R7: lower select 110 counts clock divided by four
// R8: overflow flag bit 7 set on overflow
// R9: compare-match flag bit 6 set on match
// R10: overflow enable bit 5 gates overflow requests
// R11: clear bit 4 low keeps count on match
// R12: 16-bit counting overflows after 65536 ticks
// R13: enable register bit 3 gates upper interrupt
// R14: request register bit 3 shows pending upper interrupt
// R15: count value upper and lower bytes mapped together
// R16: counter wraps; request needs both enables set
// R17: software clears overflow and request flags afterward
//
// Decided for this implementation: register access over AXI4-Lite.
module tmf_timer
	import tmf_pkg::*;
#(
	parameter int PRESCALE_BITS = tmf_pkg::PRESCALE_W
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic ext_clk_in,
	input wire logic [tmf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tmf_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic timer_irq_req,
	output logic upper_toggle_out_pin,
	output logic lower_toggle_out_pin
);
	import tmf_pkg::*;

	// ==========================================
	// state
	logic [PRESCALE_BITS-1:0] system_prescaler;
	logic ext_prev;
	logic [7:0] timer_control;
	logic [7:0] timer_control_status;
	logic [7:0] count_upper_byte;
	logic [7:0] count_lower_byte;
	logic [15:0] compare_value;
	logic [EV_W-1:0] event_status;
	logic [EV_W-1:0] event_mask;
	logic [7:0] interrupt_enable_two;
	logic upper_timer_irq_pending;
	logic [IDX_W-1:0] aw_idx;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// ==========================================
	// helpers
	logic [7:0] next_upper;
	logic [7:0] next_lower;
	logic [7:0] next_status;
	logic [EV_W-1:0] next_events;
	logic do_write;
	logic wr_ctl;
	logic wr_cs;
	logic wr_cnt;
	logic wr_cmp;
	logic wr_evs;
	logic wr_evm;
	logic wr_ien;
	logic wr_irr;
	logic tick_div4;
	logic tick_div16;
	logic tick_div32;
	logic tick_ext;
	logic mode16;
	logic lo_tick;
	logic hi_tick;
	logic match16;
	logic ovf16;
	logic match_lo;
	logic ovf_lo;
	logic match_hi;
	logic ovf_hi;
	logic ev_ovf_h;
	logic ev_cmp_h;
	logic ev_ovf_l;
	logic ev_cmp_l;

	// decode of a 3-bit clock select into a count tick, used by both halves
	function automatic logic sel_tick(input logic [2:0] sel);
		case (sel)
			SEL_DIV4: sel_tick = tick_div4;
			SEL_DIV16: sel_tick = tick_div16;
			SEL_DIV32: sel_tick = tick_div32;
			default: sel_tick = sel[SEL_INTERNAL_BIT] ? 1'b0 : tick_ext;
		endcase
	endfunction

	// address decode shared by the read and the write path
	function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_TIMER_CONTROL, IDX_TIMER_CONTROL_STATUS, IDX_TIMER_COUNT_VALUE,
			IDX_COMPARE_VALUE, IDX_EVENT_STATUS, IDX_EVENT_MASK,
			IDX_INTERRUPT_ENABLE_TWO, IDX_INTERRUPT_REQUEST_TWO: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] read_word(input logic [IDX_W-1:0] idx);
		read_word = '0;
		case (idx)
			IDX_TIMER_CONTROL: read_word[7:0] = timer_control;
			IDX_TIMER_CONTROL_STATUS: read_word[7:0] = timer_control_status;
			IDX_TIMER_COUNT_VALUE: read_word[15:0] = {count_upper_byte, count_lower_byte}; // R15
			IDX_COMPARE_VALUE: read_word[15:0] = compare_value;
			IDX_EVENT_STATUS: read_word[EV_W-1:0] = event_status;
			IDX_EVENT_MASK: read_word[EV_W-1:0] = event_mask;
			IDX_INTERRUPT_ENABLE_TWO: read_word[7:0] = interrupt_enable_two;
			IDX_INTERRUPT_REQUEST_TWO: read_word[IRQ_UPPER_BIT] = upper_timer_irq_pending; // R14
			default: read_word = '0;
		endcase
	endfunction

	// ==========================================
	// write channels: address and data taken in either order, held until response
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			aw_idx <= '0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_idx <= s_axi_awaddr[ADDR_W-1:2];
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b1;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else if (ce)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_wready <= 1'b1;
		end
	end

	// response one cycle after both halves are held; unmapped gets SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// per-register write strobes, low byte lane must be enabled except for count and compare, which test each lane
	assign wr_ctl = do_write && wstrb_q[0] && aw_idx == IDX_TIMER_CONTROL;
	assign wr_cs = do_write && wstrb_q[0] && aw_idx == IDX_TIMER_CONTROL_STATUS;
	assign wr_cnt = do_write && aw_idx == IDX_TIMER_COUNT_VALUE;
	assign wr_cmp = do_write && aw_idx == IDX_COMPARE_VALUE;
	assign wr_evs = do_write && wstrb_q[0] && aw_idx == IDX_EVENT_STATUS;
	assign wr_evm = do_write && wstrb_q[0] && aw_idx == IDX_EVENT_MASK;
	assign wr_ien = do_write && wstrb_q[0] && aw_idx == IDX_INTERRUPT_ENABLE_TWO;
	assign wr_irr = do_write && wstrb_q[0] && aw_idx == IDX_INTERRUPT_REQUEST_TWO;

	// ==========================================
	// read channel: data sampled at the address handshake, shown next cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_word(s_axi_araddr[ADDR_W-1:2]);
				s_axi_rresp <= is_mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================
	// prescaler and tick sources
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			system_prescaler <= '0;
		else if (ce)
			system_prescaler <= system_prescaler + 1'b1; // R1
	end

	// ext input is synchronous, so a simple previous-value edge detect suffices
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_prev <= 1'b0;
		else if (ce)
			ext_prev <= ext_clk_in;
	end

	// a tap fires once per divisor period, where the low bits roll over
	assign tick_div4 = ce && (&system_prescaler[$clog2(DIV4)-1:0]); // R3 R7
	assign tick_div16 = ce && (&system_prescaler[$clog2(DIV16)-1:0]); // R3
	assign tick_div32 = ce && (&system_prescaler[$clog2(DIV32)-1:0]); // R3
	assign tick_ext = ce && ext_clk_in && !ext_prev; // R3

	// ==========================================
	// counting
	assign mode16 = !timer_control[CTL_UPPER_SEL_HI]; // R4 R6
	// kept in a process so the taps read inside the function wake it up
	always_comb
	begin
		lo_tick = sel_tick(timer_control[CTL_LOWER_SEL_HI:CTL_LOWER_SEL_LO]); // R7
		hi_tick = sel_tick(timer_control[CTL_UPPER_SEL_HI:CTL_UPPER_SEL_LO]);
	end

	// 16-bit: lower half tick carries into the upper half
	assign match16 = lo_tick && {count_upper_byte, count_lower_byte} == compare_value;
	assign ovf16 = lo_tick && {count_upper_byte, count_lower_byte} == {BYTE_MAX, BYTE_MAX}; // R12
	assign match_lo = lo_tick && count_lower_byte == compare_value[7:0];
	assign ovf_lo = lo_tick && count_lower_byte == BYTE_MAX;
	assign match_hi = hi_tick && count_upper_byte == compare_value[15:8];
	assign ovf_hi = hi_tick && count_upper_byte == BYTE_MAX;

	assign ev_ovf_h = mode16 ? ovf16 : ovf_hi; // R8
	assign ev_cmp_h = mode16 ? match16 : match_hi; // R9
	assign ev_ovf_l = !mode16 && ovf_lo;
	assign ev_cmp_l = !mode16 && match_lo;

	// next count; a software write to a byte wins over a tick on that byte
	always_comb
	begin
		next_upper = count_upper_byte;
		next_lower = count_lower_byte;
		if (mode16)
		begin
			if (match16 && timer_control_status[CS_CCLR_H]) // R11
				{next_upper, next_lower} = RST_WORD;
			else if (lo_tick)
				{next_upper, next_lower} = {count_upper_byte, count_lower_byte} + 1'b1; // R2 R16
		end
		else
		begin
			if (match_lo && timer_control_status[CS_CCLR_L])
				next_lower = RST_BYTE;
			else if (lo_tick)
				next_lower = count_lower_byte + BYTE_ONE;
			if (match_hi && timer_control_status[CS_CCLR_H]) // R11
				next_upper = RST_BYTE;
			else if (hi_tick)
				next_upper = count_upper_byte + BYTE_ONE;
		end
		if (wr_cnt && wstrb_q[0])
			next_lower = wdata_q[7:0]; // R2
		if (wr_cnt && wstrb_q[1])
			next_upper = wdata_q[15:8]; // R2
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_upper_byte <= RST_BYTE;
			count_lower_byte <= RST_BYTE;
		end
		else if (ce)
		begin
			count_upper_byte <= next_upper;
			count_lower_byte <= next_lower;
		end
	end

	// ==========================================
	// control and compare registers; writing control also sets pin levels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_control <= RST_BYTE;
			upper_toggle_out_pin <= 1'b0;
			lower_toggle_out_pin <= 1'b0;
		end
		else if (ce && wr_ctl)
		begin
			timer_control <= wdata_q[7:0]; // R4 R5
			upper_toggle_out_pin <= wdata_q[CTL_UPPER_LEVEL]; // R5
			lower_toggle_out_pin <= wdata_q[CTL_LOWER_LEVEL]; // R5
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			compare_value <= RST_COMPARE;
		else if (ce && wr_cmp)
		begin
			if (wstrb_q[0])
				compare_value[7:0] <= wdata_q[7:0];
			if (wstrb_q[1])
				compare_value[15:8] <= wdata_q[15:8];
		end
	end

	// ==========================================
	// status flags: written 0 clears a flag, a same-cycle event still sets it
	always_comb
	begin
		logic [7:0] ev;
		ev = '0;
		ev[CS_OVF_H] = ev_ovf_h;
		ev[CS_CMP_H] = ev_cmp_h;
		ev[CS_OVF_L] = ev_ovf_l;
		ev[CS_CMP_L] = ev_cmp_l;
		for (int i = 0; i < 8; i++)
		begin
			if (CS_FLAG_MASK[i])
				next_status[i] = ev[i] || (timer_control_status[i] && !(wr_cs && !wdata_q[i]));
			else
				next_status[i] = wr_cs ? wdata_q[i] : timer_control_status[i];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_control_status <= RST_BYTE;
		else if (ce)
			timer_control_status <= next_status; // R8 R9 R10 R11 R17
	end

	// ==========================================
	// upper timer request: set only when overflow enable is on
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			upper_timer_irq_pending <= 1'b0;
		else if (ce)
		begin
			if (ev_ovf_h && timer_control_status[CS_OVIE_H]) // R10 R16
				upper_timer_irq_pending <= 1'b1;
			else if (wr_irr && !wdata_q[IRQ_UPPER_BIT])
				upper_timer_irq_pending <= 1'b0; // R17
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			interrupt_enable_two <= RST_BYTE;
		else if (ce && wr_ien)
			interrupt_enable_two <= wdata_q[7:0];
	end

	// request line mirrors pending gated by the enable, one cycle late
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_irq_req <= 1'b0;
		else if (ce)
			timer_irq_req <= upper_timer_irq_pending && interrupt_enable_two[IRQ_UPPER_BIT]; // R13 R16
	end

	// ==========================================
	// sticky event status, write one to clear, masked onto irq
	always_comb
	begin
		next_events = event_status;
		if (wr_evs)
			next_events = event_status & ~wdata_q[EV_W-1:0];
		next_events[EV_OVF_H] = next_events[EV_OVF_H] || ev_ovf_h;
		next_events[EV_CMP_H] = next_events[EV_CMP_H] || ev_cmp_h;
		next_events[EV_OVF_L] = next_events[EV_OVF_L] || ev_ovf_l;
		next_events[EV_CMP_L] = next_events[EV_CMP_L] || ev_cmp_l;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			event_status <= '0;
			event_mask <= '0;
		end
		else if (ce)
		begin
			event_status <= next_events;
			if (wr_evm)
				event_mask <= wdata_q[EV_W-1:0];
		end
	end

	// irq follows the stored status, so it lags a new event by two cycles
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else if (ce)
			irq <= |(event_status & event_mask);
	end

endmodule

// [tb/tmf_timer_checker.sv]
// concurrent checks on the interval timer's bus answers, pins and readback
// assumes binding into tmf_timer with one clock; ce drops only briefly, bus idle
module tmf_timer_checker
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [tmf_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_irq_req,
	input wire logic upper_toggle_out_pin,
	input wire logic lower_toggle_out_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import tmf_pkg::*;

	// ========
	// helper: index of the read in flight, so rdata can be judged per register
	logic [IDX_W-1:0] rd_idx;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_idx <= '0;
		else if (ce && s_axi_arvalid && s_axi_arready)
			rd_idx <= s_axi_araddr[ADDR_W-1:2];
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ========
	// properties
	sequence s_both_taken;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_write_answer;
		s_both_taken |=> s_b_late;
	endproperty
	property p_write_release;
		s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	property p_write_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_read_answer;
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_read_release;
		ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	// pins move only while a write is offered or in flight
	property p_pin_cause;
		$changed(upper_toggle_out_pin) || $changed(lower_toggle_out_pin)
			|-> $past(s_axi_awvalid) || !$past(s_axi_awready);
	endproperty
	property p_ctl_read;
		s_axi_rvalid && rd_idx == IDX_TIMER_CONTROL |-> s_axi_rdata[31:8] == 24'h0
			&& s_axi_rdata[7] == upper_toggle_out_pin && s_axi_rdata[3] == lower_toggle_out_pin;
	endproperty
	property p_req_read;
		s_axi_rvalid && rd_idx == IDX_INTERRUPT_REQUEST_TWO |-> s_axi_rdata[31:4] == 28'h0
			&& s_axi_rdata[2:0] == 3'h0 && (!timer_irq_req || s_axi_rdata[3]);
	endproperty
	property p_cnt_read;
		s_axi_rvalid && rd_idx == IDX_TIMER_COUNT_VALUE |-> s_axi_rdata[31:16] == 16'h0;
	endproperty

	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	a_write_release: assert property (p_write_release) else $error("write not released");
	a_write_block: assert property (p_write_block) else $error("write taken too early");
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	a_read_release: assert property (p_read_release) else $error("read not released");
	a_err_zero: assert property (p_err_zero) else $error("error read with data");
	a_pin_cause: assert property (p_pin_cause) else $error("pin moved without write");
	a_ctl_read: assert property (p_ctl_read) else $error("control read off pins");
	a_req_read: assert property (p_req_read) else $error("request read wrong");
	a_cnt_read: assert property (p_cnt_read) else $error("count read too wide");
endmodule

// [tb/tmf_timer_tb.sv]
// self-checking bench for the interval timer: registers, rates, modes, flags, interrupts
// assumes tmf_pkg and tmf_timer compiled first; the bench drives every port itself
module tmf_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tmf_pkg::*;
	localparam int LIMIT = 20000;
	logic aclk, aresetn, ce, ext_clk_in, irq, timer_irq_req;
	logic upper_toggle_out_pin, lower_toggle_out_pin;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int c1;

	tmf_timer i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .ext_clk_in(ext_clk_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq(irq), .timer_irq_req(timer_irq_req),
		.upper_toggle_out_pin(upper_toggle_out_pin), .lower_toggle_out_pin(lower_toggle_out_pin));

	// ========
	// clock, hang guard, shared tasks
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// a stuck handshake would otherwise hang the run
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			n_fail++;
			final_report;
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// range compare for counts whose phase against the prescaler is free
	task automatic in_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
		total_checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		wr_r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [IDX_W-1:0] idx);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// ========
	// scenarios
	task automatic t_reset;
		logic [IDX_W-1:0] ix [8];
		ix = '{IDX_TIMER_CONTROL, IDX_TIMER_CONTROL_STATUS, IDX_TIMER_COUNT_VALUE,
			IDX_COMPARE_VALUE, IDX_EVENT_STATUS, IDX_EVENT_MASK, IDX_INTERRUPT_ENABLE_TWO,
			IDX_INTERRUPT_REQUEST_TWO};
		foreach (ix[i])
		begin
			rd(ix[i]);
			chk("reset value", (ix[i] == IDX_COMPARE_VALUE) ? 32'h0000FFFF : 32'h0, rd_d);
			chk("reset resp", 32'(RESP_OKAY), 32'(rd_r));
		end
		chk("reset outputs", 32'h0,
			32'({irq, timer_irq_req, upper_toggle_out_pin, lower_toggle_out_pin}));
		wr(16'h0000, 32'hFFFFFFFF);
		chk("unmapped write resp", 32'(RESP_SLVERR), 32'(wr_r));
		rd(16'h0000);
		chk("unmapped read resp", 32'(RESP_SLVERR), 32'(rd_r));
	endtask

	task automatic t_pins;
		for (int i = 0; i < 4; i++)
		begin
			wr(IDX_TIMER_CONTROL, {24'h0, i[1], 3'h0, i[0], SEL_DIV4});
			repeat (2) @(posedge aclk);
			chk("toggle pins", 32'(i[1:0]), 32'({upper_toggle_out_pin, lower_toggle_out_pin}));
		end
	endtask

	// tick count over a measured span, for each divided clock
	task automatic t_rates;
		logic [2:0] sel [3];
		int dv [3];
		int ex;
		sel = '{SEL_DIV4, SEL_DIV16, SEL_DIV32};
		dv = '{DIV4, DIV16, DIV32};
		foreach (sel[i])
		begin
			wr(IDX_TIMER_CONTROL, {29'h0, sel[i]});
			wr(IDX_TIMER_COUNT_VALUE, 32'h0);
			c1 = cyc;
			repeat (640) @(posedge aclk);
			rd(IDX_TIMER_COUNT_VALUE);
			ex = (cyc - c1) / dv[i];
			in_rng("tick rate", ex - 2, ex + 2, rd_d);
		end
		wr(IDX_TIMER_CONTROL, 32'h0);
		wr(IDX_TIMER_COUNT_VALUE, 32'h0);
		repeat (20)
		begin
			repeat (2) @(posedge aclk);
			ext_clk_in <= !ext_clk_in;
		end
		repeat (4) @(posedge aclk);
		rd(IDX_TIMER_COUNT_VALUE);
		chk("external ticks", 32'h0000000A, rd_d);
		// ce low must freeze the edge detector and count; two edges pass unseen
		ce <= 1'b0;
		repeat (4) @(posedge aclk) ext_clk_in <= !ext_clk_in;
		ce <= 1'b1;
		rd(IDX_TIMER_COUNT_VALUE);
		chk("frozen count", 32'h0000000A, rd_d);
	endtask

	// carry into the upper byte only in the 16-bit codes
	task automatic t_modes;
		logic [2:0] cd [4];
		cd = '{3'h0, 3'h1, 3'h2, 3'h7};
		foreach (cd[i])
		begin
			wr(IDX_TIMER_CONTROL, {24'h0, 1'b0, cd[i], 1'b0, SEL_DIV4});
			wr(IDX_TIMER_COUNT_VALUE, 32'h000000FE);
			repeat (40) @(posedge aclk);
			rd(IDX_TIMER_COUNT_VALUE);
			chk("upper byte", (i < 3) ? 32'h1 : 32'h0, 32'(rd_d[15:8]));
		end
	endtask

	// counter parked while set up, then released just below the wrap
	task automatic ovf_run(input logic ovie, input logic ena, input logic pend, input logic req);
		wr(IDX_TIMER_CONTROL, 32'h7);
		wr(IDX_COMPARE_VALUE, 32'h10);
		wr(IDX_INTERRUPT_REQUEST_TWO, 32'h0);
		wr(IDX_TIMER_CONTROL_STATUS, {26'h0, ovie, 5'h0});
		wr(IDX_INTERRUPT_ENABLE_TWO, {28'h0, ena, 3'h0});
		wr(IDX_TIMER_COUNT_VALUE, 32'h0000FFF0);
		wr(IDX_TIMER_CONTROL, {29'h0, SEL_DIV4});
		repeat (20) @(posedge aclk);
		rd(IDX_TIMER_CONTROL_STATUS);
		chk("flags before wrap", 32'h0, 32'(rd_d[7:6]));
		repeat (140) @(posedge aclk);
		rd(IDX_TIMER_CONTROL_STATUS);
		chk("flags after wrap", 32'({2'h3, ovie}), 32'(rd_d[7:5]));
		rd(IDX_TIMER_COUNT_VALUE);
		in_rng("count after wrap", 17, 64, rd_d);
		rd(IDX_INTERRUPT_REQUEST_TWO);
		chk("pending bit", {28'h0, pend, 3'h0}, rd_d);
		rd(IDX_INTERRUPT_ENABLE_TWO);
		chk("enable bit", 32'(ena), 32'(rd_d[3]));
		chk("request out", 32'(req), 32'(timer_irq_req));
		wr(IDX_TIMER_CONTROL_STATUS, {26'h0, ovie, 5'h0});
		wr(IDX_INTERRUPT_REQUEST_TWO, 32'h0);
		repeat (2) @(posedge aclk);
		rd(IDX_TIMER_CONTROL_STATUS);
		chk("flags cleared", 32'h0, 32'(rd_d[7:6]));
		chk("request cleared", 32'h0, 32'(timer_irq_req));
	endtask

	task automatic t_clear;
		wr(IDX_TIMER_CONTROL, 32'h7);
		wr(IDX_COMPARE_VALUE, 32'h20);
		wr(IDX_TIMER_CONTROL_STATUS, 32'h10);
		wr(IDX_TIMER_COUNT_VALUE, 32'h0);
		wr(IDX_TIMER_CONTROL, {29'h0, SEL_DIV4});
		repeat (400) @(posedge aclk);
		rd(IDX_TIMER_COUNT_VALUE);
		in_rng("count with clear", 0, 32, rd_d);
		rd(IDX_TIMER_CONTROL_STATUS);
		chk("match flag", 32'h1, 32'(rd_d[CS_CMP_H]));
	endtask

	// overflow event already latched by the runs above
	task automatic t_events;
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, 32'(irq));
		wr(IDX_EVENT_MASK, 32'h8);
		repeat (2) @(posedge aclk);
		chk("irq unmasked", 32'h1, 32'(irq));
		wr(IDX_EVENT_STATUS, 32'h8);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, 32'(irq));
		rd(IDX_EVENT_STATUS);
		chk("match event kept", 32'h1, 32'(rd_d[EV_CMP_H]));
	endtask

	// ========
	// main sequence
	initial
	begin
		aresetn = 1'b0;
		ce = 1'b1;
		ext_clk_in = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_pins;
		t_rates;
		t_modes;
		ovf_run(1'b1, 1'b1, 1'b1, 1'b1);
		ovf_run(1'b1, 1'b0, 1'b1, 1'b0);
		ovf_run(1'b0, 1'b1, 1'b0, 1'b0);
		t_clear;
		t_events;
		final_report;
	end
endmodule

bind tmf_timer tmf_timer_checker i_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_araddr(s_axi_araddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .timer_irq_req(timer_irq_req),
	.upper_toggle_out_pin(upper_toggle_out_pin), .lower_toggle_out_pin(lower_toggle_out_pin));
